/* design/idj_regs.svh */
// Purpose: Offsets, field positions, encodings and timing counts of the execution block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Included by the package and the top module
`ifndef IDJ_REGS_SVH
`define IDJ_REGS_SVH

`define IDJ_OFS_CTRL 8'h00
`define IDJ_OFS_OPCODE 8'h04
`define IDJ_OFS_NEXT_WORD 8'h08
`define IDJ_OFS_ACC 8'h0C
`define IDJ_OFS_BANK 8'h10
`define IDJ_OFS_FLAGS 8'h14
`define IDJ_OFS_PCNT 8'h18
`define IDJ_OFS_STATUS 8'h1C
`define IDJ_OFS_RESULT 8'h20

`define IDJ_CTRL_GO 0
`define IDJ_FLAG_CARRY 0
`define IDJ_FLAG_DIGIT 1
`define IDJ_ST_BUSY 0
`define IDJ_ST_SKIP 1
`define IDJ_ST_BAD 2
`define IDJ_ST_CYC_LO 4

`define IDJ_RST_WORD 32'h0000_0000
`define IDJ_RST_BYTE 8'h00
`define IDJ_RST_PC 21'h0_0000
`define IDJ_OP_DEC 6'h01
`define IDJ_OP_DECSZ 6'h0B
`define IDJ_OP_DECSNZ 6'h13
`define IDJ_OP_INC 6'h0A
`define IDJ_OP_INCSZ 6'h0F
`define IDJ_OP_INCSNZ 6'h12
`define IDJ_OP_JUMP 8'hEF
`define IDJ_OP_BCD 16'h0007
`define IDJ_TW_MOVE 4'hC
`define IDJ_TW_CALL 7'h76
`define IDJ_TW_LOAD 10'h3B8
`define IDJ_ACCESS_SPLIT 8'h80
`define IDJ_ACCESS_HIGH 4'hF
`define IDJ_BCD_LIMIT 4'h9
`define IDJ_BCD_ADD 4'h6
`define IDJ_Q_PHASES 2'd3
`define IDJ_PC_STEP 21'h0_0002

`endif

/* design/idj_pkg.sv */
// Purpose: Types and decode helpers shared by the execution block
// Assumes: Encodings come from the constants header
// Notes: Decode is a function as both the top and status logic use it
`include "idj_regs.svh"
package idj_pkg;

    typedef enum logic [3:0] {OP_DEC, OP_DECSZ, OP_DECSNZ, OP_INC, OP_INCSZ, OP_INCSNZ,
                              OP_JUMP, OP_BCD, OP_BAD} idj_op_e;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} idj_state_e;

    typedef struct packed {
        idj_op_e op;
        logic dest_file;
        logic bank_sel;
        logic [7:0] file_addr;
    } idj_instr_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } idj_dmem_req_s;

    function automatic idj_instr_s idj_decode(input logic [15:0] w);
        idj_instr_s d;
        d.dest_file = w[9];
        d.bank_sel = w[8];
        d.file_addr = w[7:0];
        case (w[15:10])
            `IDJ_OP_DEC: d.op = OP_DEC;
            `IDJ_OP_DECSZ: d.op = OP_DECSZ;
            `IDJ_OP_DECSNZ: d.op = OP_DECSNZ;
            `IDJ_OP_INC: d.op = OP_INC;
            `IDJ_OP_INCSZ: d.op = OP_INCSZ;
            `IDJ_OP_INCSNZ: d.op = OP_INCSNZ;
            default: d.op = OP_BAD;
        endcase
        if (w[15:8] == `IDJ_OP_JUMP)
        begin
            d.op = OP_JUMP;
        end
        if (w == `IDJ_OP_BCD)
        begin
            d.op = OP_BCD;
        end
        return d;
    endfunction : idj_decode

    function automatic logic idj_two_word(input logic [15:0] w);
        return (w[15:12] == `IDJ_TW_MOVE) || (w[15:9] == `IDJ_TW_CALL) ||
               (w[15:8] == `IDJ_OP_JUMP) || (w[15:6] == `IDJ_TW_LOAD);
    endfunction : idj_two_word

endpackage : idj_pkg

/* design/idj_addr_map.sv */
// Purpose: Resolve an 8-bit file address into a 12-bit data address
// Assumes: Access bank low half is RAM, high half maps to the top bank
// Notes: Pure combinational
`include "idj_regs.svh"
module idj_addr_map
    import idj_pkg::*;
(
    input wire logic bank_sel,
    input wire logic [7:0] file_addr,
    input wire logic [7:0] bank_select_reg,
    output logic [11:0] data_addr
);
    always_comb
    begin
        if (bank_sel)
        begin
            data_addr = {bank_select_reg[3:0], file_addr};
        end
        else if (file_addr < `IDJ_ACCESS_SPLIT)
        begin
            data_addr = {4'h0, file_addr};
        end
        else
        begin
            data_addr = {`IDJ_ACCESS_HIGH, file_addr};
        end
    end
endmodule : idj_addr_map

/* design/idj_bcd_adjust.sv */
// Purpose: Packed-BCD correction of the accumulator after an addition
// Assumes: Carry and digit carry reflect the preceding addition
// Notes: Low correction may ripple into the high nibble before its test
`include "idj_regs.svh"
module idj_bcd_adjust
    import idj_pkg::*;
(
    input wire logic [7:0] acc_in,
    input wire logic carry_in,
    input wire logic digit_carry,
    output logic [7:0] acc_out,
    output logic carry_out
);
    logic [8:0] lo_sum;
    logic [8:0] hi_sum;
    logic hi_fix;

    always_comb
    begin
        lo_sum = {1'b0, acc_in};
        if ((acc_in[3:0] > `IDJ_BCD_LIMIT) || digit_carry)
        begin
            lo_sum = {1'b0, acc_in} + {5'h00, `IDJ_BCD_ADD};
        end
        // High nibble is corrected when above 9 or when the carry flag is set; a low ripple out of bit 7 just sets carry
        hi_fix = (lo_sum[7:4] > `IDJ_BCD_LIMIT) || carry_in;
        hi_sum = lo_sum;
        if (hi_fix)
        begin
            hi_sum = lo_sum + {1'b0, `IDJ_BCD_ADD, 4'h0};
        end
        acc_out = hi_sum[7:0];
        carry_out = carry_in | lo_sum[8] | hi_sum[8];
    end
endmodule : idj_bcd_adjust

/* design/idj_exec.sv */
// Purpose: Executes increment/decrement-with-skip, long jump and BCD adjust
// Assumes: APB master, data memory answering one clock after a read strobe
// Notes: One instruction cycle is four ref_clk periods (Q1..Q4)
//
// Local design decisions: the APB interface to the registers and the address map.
`include "idj_regs.svh"
module idj_exec
    import idj_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int PADDR_W = 8
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output idj_dmem_req_s dmem_req,
    input wire logic [7:0] dmem_rdata
);
    if (PC_W != 21)
    begin : g_pc_check
        $error("program counter width must be 21");
    end
    if (PADDR_W < 6)
    begin : g_addr_check
        $error("APB address too narrow for register map");
    end

    idj_state_e state;
    logic [1:0] qphase;
    logic [1:0] flush_left;
    logic [15:0] opcode;
    logic [15:0] next_word;
    logic [7:0] acc;
    logic [7:0] bank_select_reg;
    logic carry;
    logic digit_carry;
    logic [PC_W-1:0] program_counter;
    logic [7:0] result;
    logic skipped;
    logic bad_op;
    logic [1:0] cycles_taken;
    idj_instr_s instr;
    idj_instr_s held;
    logic [11:0] data_addr;
    logic [7:0] bcd_value;
    logic bcd_carry;
    logic [7:0] next_result;
    logic skip_now;
    logic [1:0] next_flush;
    logic go_req;
    logic apb_setup;
    logic [7:0] reg_ofs;
    logic busy;
    logic [31:0] next_rdata;
    logic next_err;

    assign instr = idj_decode(opcode);
    assign busy = (state != ST_IDLE);
    assign apb_setup = psel && !penable;
    assign reg_ofs = paddr[7:0];
    assign go_req = apb_setup && pwrite && !busy && (reg_ofs == `IDJ_OFS_CTRL) && pwdata[`IDJ_CTRL_GO];

    idj_addr_map u_addr_map
    (
        .bank_sel(held.bank_sel),
        .file_addr(held.file_addr),
        .bank_select_reg(bank_select_reg),
        .data_addr(data_addr)
    );

    idj_bcd_adjust u_bcd
    (
        .acc_in(acc),
        .carry_in(carry),
        .digit_carry(digit_carry),
        .acc_out(bcd_value),
        .carry_out(bcd_carry)
    );

    // Operand arrives during Q3; arithmetic is taken straight from the memory bus
    always_comb
    begin
        case (held.op)
            OP_DEC, OP_DECSZ, OP_DECSNZ: next_result = dmem_rdata - 8'h01;
            OP_INC, OP_INCSZ, OP_INCSNZ: next_result = dmem_rdata + 8'h01;
            default: next_result = dmem_rdata;
        endcase
    end

    always_comb
    begin
        case (held.op)
            OP_DECSZ, OP_INCSZ: skip_now = (result == 8'h00);
            OP_DECSNZ, OP_INCSNZ: skip_now = (result != 8'h00);
            default: skip_now = 1'b0;
        endcase
        if (skip_now)
        begin
            next_flush = idj_two_word(next_word) ? 2'd2 : 2'd1;
        end
        else if (held.op == OP_JUMP)
        begin
            next_flush = 2'd1;
        end
        else
        begin
            next_flush = 2'd0;
        end
    end

    // Sequencer: one Q-phase counter, then idle cycles for flushes
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            qphase <= 2'd0;
            flush_left <= 2'd0;
            held <= '{op: OP_BAD, dest_file: 1'b0, bank_sel: 1'b0, file_addr: 8'h00};
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    qphase <= 2'd0;
                    if (go_req)
                    begin
                        held <= instr;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    qphase <= qphase + 2'd1;
                    if (qphase == `IDJ_Q_PHASES)
                    begin
                        flush_left <= next_flush;
                        state <= (next_flush != 2'd0) ? ST_FLUSH : ST_IDLE;
                    end
                end
                ST_FLUSH:
                begin
                    qphase <= qphase + 2'd1;
                    if (qphase == `IDJ_Q_PHASES)
                    begin
                        flush_left <= flush_left - 2'd1;
                        if (flush_left == 2'd1)
                        begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Data memory strobes: read in Q2, write in Q4
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dmem_req <= '{rd: 1'b0, wr: 1'b0, addr: 12'h000, wdata: 8'h00};
        end
        else
        begin
            dmem_req.rd <= 1'b0;
            dmem_req.wr <= 1'b0;
            if (state == ST_EXEC)
            begin
                case (qphase)
                    2'd0:
                    begin
                        dmem_req.addr <= data_addr;
                        dmem_req.rd <= (held.op inside {OP_DEC, OP_DECSZ, OP_DECSNZ, OP_INC, OP_INCSZ, OP_INCSNZ});
                    end
                    2'd2:
                    begin
                        dmem_req.wdata <= next_result;
                        dmem_req.wr <= held.dest_file && (held.op inside {OP_DEC, OP_DECSZ, OP_DECSNZ,
                                                                         OP_INC, OP_INCSZ, OP_INCSNZ});
                    end
                    default:
                    begin
                        dmem_req.rd <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Result, accumulator and carries
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result <= 8'h00;
            acc <= `IDJ_RST_BYTE;
            carry <= 1'b0;
            digit_carry <= 1'b0;
            bank_select_reg <= `IDJ_RST_BYTE;
        end
        else if (state == ST_EXEC)
        begin
            if ((qphase == 2'd2) && (held.op != OP_BCD))
            begin
                result <= next_result;
            end
            if (qphase == `IDJ_Q_PHASES)
            begin
                if (held.op == OP_BCD)
                begin
                    acc <= bcd_value;
                    carry <= bcd_carry;
                    result <= bcd_value;
                end
                else if (!held.dest_file && (held.op inside {OP_DEC, OP_DECSZ, OP_DECSNZ,
                                                              OP_INC, OP_INCSZ, OP_INCSNZ}))
                begin
                    acc <= result;
                end
            end
        end
        else if (apb_setup && pwrite && !busy)
        begin
            case (reg_ofs)
                `IDJ_OFS_ACC: acc <= pwdata[7:0];
                `IDJ_OFS_BANK: bank_select_reg <= pwdata[7:0];
                `IDJ_OFS_FLAGS:
                begin
                    carry <= pwdata[`IDJ_FLAG_CARRY];
                    digit_carry <= pwdata[`IDJ_FLAG_DIGIT];
                end
                default: result <= result;
            endcase
        end
    end

    // Program counter, status of the last instruction
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            program_counter <= `IDJ_RST_PC;
            skipped <= 1'b0;
            bad_op <= 1'b0;
            cycles_taken <= 2'd0;
        end
        else if ((state == ST_EXEC) && (qphase == `IDJ_Q_PHASES))
        begin
            skipped <= skip_now;
            bad_op <= (held.op == OP_BAD);
            cycles_taken <= 2'd1 + next_flush;
            if (held.op == OP_JUMP)
            begin
                // Full 20-bit literal, no paging; bit 0 forced low
                program_counter <= {next_word[11:0], opcode[7:0], 1'b0};
            end
            else
            begin
                program_counter <= program_counter + `IDJ_PC_STEP +
                                   (skip_now ? {19'h0_0000, next_flush} << 1 : 21'h0_0000);
            end
        end
        else if (apb_setup && pwrite && !busy && (reg_ofs == `IDJ_OFS_PCNT))
        begin
            program_counter <= {pwdata[PC_W-1:1], 1'b0};
        end
    end

    // Instruction words: writable only while idle
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            opcode <= 16'h0000;
            next_word <= 16'h0000;
        end
        else if (apb_setup && pwrite && !busy)
        begin
            if (reg_ofs == `IDJ_OFS_OPCODE)
            begin
                opcode <= pwdata[15:0];
            end
            if (reg_ofs == `IDJ_OFS_NEXT_WORD)
            begin
                next_word <= pwdata[15:0];
            end
        end
    end

    // APB read mux and error decode
    always_comb
    begin
        next_rdata = `IDJ_RST_WORD;
        next_err = 1'b0;
        case (reg_ofs)
            `IDJ_OFS_CTRL: next_rdata = `IDJ_RST_WORD;
            `IDJ_OFS_OPCODE: next_rdata = {16'h0000, opcode};
            `IDJ_OFS_NEXT_WORD: next_rdata = {16'h0000, next_word};
            `IDJ_OFS_ACC: next_rdata = {24'h00_0000, acc};
            `IDJ_OFS_BANK: next_rdata = {24'h00_0000, bank_select_reg};
            `IDJ_OFS_FLAGS: next_rdata = {30'h0000_0000, digit_carry, carry};
            `IDJ_OFS_PCNT: next_rdata = {11'h000, program_counter};
            `IDJ_OFS_STATUS: next_rdata = {26'h000_0000, cycles_taken, 1'b0, bad_op, skipped, busy};
            `IDJ_OFS_RESULT: next_rdata = {24'h00_0000, result};
            default: next_err = 1'b1;
        endcase
        if (pwrite && busy && (reg_ofs != `IDJ_OFS_STATUS))
        begin
            // Changing operands mid-instruction would corrupt it
            next_err = 1'b1;
        end
        if (pwrite && (reg_ofs == `IDJ_OFS_STATUS || reg_ofs == `IDJ_OFS_RESULT))
        begin
            next_err = 1'b1;
        end
        if (paddr[1:0] != 2'b00 || (PADDR_W > 8 && paddr >= PADDR_W'(256)))
        begin
            next_err = 1'b1;
        end
    end

    // Zero-wait slave: answer registered in setup, shown in access phase
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `IDJ_RST_WORD;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup && next_err;
            prdata <= (apb_setup && !pwrite && !next_err) ? next_rdata : `IDJ_RST_WORD;
        end
    end

endmodule : idj_exec

/* dv/idj_exec_checker.sv */
// Purpose: Port assertions for the execution block
// Assumes: Opcode and bank are written only while idle
// Notes: Opcode and bank are shadowed from APB setup writes
`include "idj_regs.svh"
module idj_exec_checker
    import idj_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int PADDR_W = 8
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire idj_dmem_req_s dmem_req,
    input wire logic [7:0] dmem_rdata
);
    logic [15:0] op_q;
    logic [3:0] bank_q;
    logic set_wr;
    logic go;
    logic is_inc;
    logic is_dec;
    logic rd;
    assign rd = dmem_req.rd;
    assign set_wr = psel && !penable && pwrite;
    assign go = set_wr && paddr == `IDJ_OFS_CTRL && pwdata[`IDJ_CTRL_GO];
    assign is_inc = op_q[15:10] inside {`IDJ_OP_INC, `IDJ_OP_INCSZ, `IDJ_OP_INCSNZ};
    assign is_dec = op_q[15:10] inside {`IDJ_OP_DEC, `IDJ_OP_DECSZ, `IDJ_OP_DECSNZ};
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            op_q <= 16'h0000;
        else if (set_wr && paddr == `IDJ_OFS_OPCODE)
            op_q <= pwdata[15:0];
    end
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            bank_q <= 4'h0;
        else if (set_wr && paddr == `IDJ_OFS_BANK)
            bank_q <= pwdata[3:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    inc_value_a: assert property (rd && is_inc && op_q[9] |-> ##2
        dmem_req.wr && dmem_req.wdata == $past(dmem_rdata) + 8'h01) else $error("bad increment write");
    dec_value_a: assert property (rd && is_dec && op_q[9] |-> ##2
        dmem_req.wr && dmem_req.wdata == $past(dmem_rdata) - 8'h01) else $error("bad decrement write");
    acc_only_a: assert property (rd && !op_q[9] |=> !dmem_req.wr [*3])
        else $error("file written with accumulator destination");
    same_addr_a: assert property (rd && op_q[9] |-> ##2 dmem_req.addr == $past(dmem_req.addr, 2))
        else $error("write-back address differs");
    access_bank_a: assert property (rd && !op_q[8] |->
        dmem_req.addr == (op_q[7] ? {4'hF, op_q[7:0]} : {4'h0, op_q[7:0]})) else $error("bad access bank address");
    bank_reg_a: assert property (rd && op_q[8] |-> dmem_req.addr == {bank_q, op_q[7:0]})
        else $error("bad banked address");
    jump_quiet_a: assert property (go && op_q[15:8] == `IDJ_OP_JUMP |=> !rd [*8])
        else $error("memory read during jump");
    cover property (dmem_req.wr);
    cover property (go && op_q[15:8] == `IDJ_OP_JUMP);
    cover property (pslverr);
endmodule : idj_exec_checker

bind idj_exec idj_exec_checker #(.PC_W(PC_W), .PADDR_W(PADDR_W)) chk (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata)
);

/* dv/idj_exec_tb_top.sv */
// Purpose: Self-checking bench for the execution block
// Assumes: Zero-wait APB slave, data memory kept here
// Notes: Skip and jump lengths are seen through the status cycle field
`include "idj_regs.svh"
`define CHK(nm, ex, gt) \
    begin \
        tests_run++; \
        if ((gt) !== (ex)) \
        begin \
            fails++; \
            $display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end
module idj_exec_tb_top
    import idj_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] dmem_rdata = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    idj_dmem_req_s dmem_req;
    logic [31:0] q;
    logic err;
    logic [7:0] mem [0:4095];
    logic [7:0] acc_m;
    logic [7:0] bank_m;
    logic c_m = 1'b0;
    logic dc_m = 1'b0;
    logic [20:0] pc_m;
    int fails = 0;
    int tests_run = 0;

    idj_exec #(.PC_W(21), .PADDR_W(8)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata)
    );

    always #2 ref_clk = ~ref_clk;

    // Idle read data keeps toggling so a late sample cannot match by luck
    always @(posedge ref_clk)
    begin
        dmem_rdata <= dmem_req.rd ? mem[dmem_req.addr] : ~dmem_rdata;
        if (dmem_req.wr)
            mem[dmem_req.addr] <= dmem_req.wdata;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // No assumed latency; only the watchdog ends a stuck wait
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic run(input logic [15:0] op, input logic [15:0] nw);
        int n;
        n = 0;
        apb(1'b1, `IDJ_OFS_OPCODE, {16'h0000, op}, q);
        apb(1'b1, `IDJ_OFS_NEXT_WORD, {16'h0000, nw}, q);
        apb(1'b1, `IDJ_OFS_ACC, {24'h00_0000, acc_m}, q);
        apb(1'b1, `IDJ_OFS_BANK, {24'h00_0000, bank_m}, q);
        apb(1'b1, `IDJ_OFS_FLAGS, {30'h0000_0000, dc_m, c_m}, q);
        apb(1'b1, `IDJ_OFS_PCNT, {11'h000, pc_m}, q);
        apb(1'b1, `IDJ_OFS_CTRL, 32'h0000_0001, q);
        do
        begin
            apb(1'b0, `IDJ_OFS_STATUS, 32'h0000_0000, q);
            n++;
        end
        while (q[`IDJ_ST_BUSY] !== 1'b0 && n < 20);
    endtask : run

    task automatic end_chk(input logic [1:0] cyc, input logic [20:0] pc_e, input logic [7:0] acc_e);
        `CHK("cycles", cyc, q[5:4])
        apb(1'b0, `IDJ_OFS_PCNT, 32'h0000_0000, q);
        `CHK("pc", pc_e, q[20:0])
        apb(1'b0, `IDJ_OFS_ACC, 32'h0000_0000, q);
        `CHK("acc", acc_e, q[7:0])
    endtask : end_chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        summarize();
    end

    initial
    begin
        logic [5:0] ops [6];
        logic [7:0] f;
        logic [7:0] v;
        logic [7:0] r8;
        logic [11:0] ad;
        logic [15:0] nw;
        logic [19:0] tgt;
        logic d;
        logic a;
        logic skip;
        int t;
        ops = '{`IDJ_OP_DEC, `IDJ_OP_DECSZ, `IDJ_OP_DECSNZ, `IDJ_OP_INC, `IDJ_OP_INCSZ, `IDJ_OP_INCSNZ};
        t = $urandom(65046);
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'($urandom);
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000, q);
            `CHK("reset value", 32'h0000_0000, q)
        end
        apb(1'b0, 8'h24, 32'h0000_0000, q);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b1, `IDJ_OFS_STATUS, 32'hFFFF_FFFF, q);
        `CHK("read-only error", 1'b1, err)
        $display("test registers done");
        for (int i = 0; i < 6; i++)
            for (int k = 0; k < 4; k++)
            begin
                f = 8'($urandom);
                d = 1'($urandom);
                a = 1'($urandom);
                bank_m = 8'($urandom);
                acc_m = 8'($urandom);
                pc_m = {1'b0, 18'($urandom), 2'b00};
                ad = a ? {bank_m[3:0], f} : (f[7] ? {4'hF, f} : {4'h0, f});
                v = (k == 0) ? ((i < 3) ? 8'h01 : 8'hFF) : 8'($urandom);
                mem[ad] = v;
                r8 = (i < 3) ? v - 8'h01 : v + 8'h01;
                skip = (i % 3 == 1 && r8 == 8'h00) || (i % 3 == 2 && r8 != 8'h00);
                nw = (k == 2) ? {4'hC, 12'($urandom)} : {(k == 3) ? 8'hEF : 8'h00, 8'($urandom)};
                run({ops[i], d, a, f}, nw);
                `CHK("skip", skip, q[`IDJ_ST_SKIP])
                end_chk(2'(1 + skip + (skip && k >= 2)),
                    pc_m + 21'h0_0002 + (skip ? ((k >= 2) ? 21'h0_0004 : 21'h0_0002) : 21'h0_0000),
                    d ? acc_m : r8);
                `CHK("memory", d ? r8 : v, mem[ad])
                apb(1'b0, `IDJ_OFS_RESULT, 32'h0000_0000, q);
                `CHK("result", r8, q[7:0])
            end
        $display("test increment and decrement done");
        for (int k = 0; k < 3; k++)
        begin
            tgt = (k == 0) ? 20'hF_FFFF : ((k == 1) ? 20'h0_0000 : 20'($urandom));
            acc_m = 8'($urandom);
            run({`IDJ_OP_JUMP, tgt[7:0]}, {4'hF, tgt[19:8]});
            end_chk(2'd2, {tgt, 1'b0}, acc_m);
        end
        $display("test jump done");
        for (int k = 0; k < 6; k++)
        begin
            acc_m = (k == 0) ? 8'hA5 : ((k == 1) ? 8'hCE : 8'($urandom));
            c_m = (k > 1) ? 1'($urandom) : 1'b0;
            dc_m = (k > 1) ? 1'($urandom) : 1'b0;
            t = acc_m;
            if (t % 16 > 9 || dc_m)
                t += 6;
            if ((t / 16) % 16 > 9 || c_m)
                t += 96;
            run(`IDJ_OP_BCD, 16'h0000);
            end_chk(2'd1, pc_m + 21'h0_0002, 8'(t));
            apb(1'b0, `IDJ_OFS_FLAGS, 32'h0000_0000, q);
            `CHK("flags", {dc_m, c_m || t > 255}, q[1:0])
        end
        $display("test bcd adjust done");
        run(16'h0000, 16'h0000);
        `CHK("bad opcode", 1'b1, q[`IDJ_ST_BAD])
        end_chk(2'd1, pc_m + 21'h0_0002, acc_m);
        $display("test bad opcode done");
        summarize();
    end
endmodule : idj_exec_tb_top
